// *** design/cnl_defs.vh ***
// Purpose: constants for the CANopen node communication and LSS block
// Assumes: 11-bit base frames, one byte per RX/TX data lane, byte 0 low
// Notes:   state codes are the ones carried in guard replies
`ifndef CNL_DEFS_VH
`define CNL_DEFS_VH

// network states (guard reply encoding)
`define CNL_ST_INIT      7'h00
`define CNL_ST_STOPPED   7'h04
`define CNL_ST_OPER      7'h05
`define CNL_ST_PREOP     7'h7F

// identifiers
`define CNL_ID_NMT       11'h000
`define CNL_ID_SYNC      11'h080
`define CNL_ID_EMCY_B    11'h080
`define CNL_ID_PDO1_B    11'h180
`define CNL_ID_SDOTX_B   11'h580
`define CNL_ID_SDORX_B   11'h600
`define CNL_ID_GUARD_B   11'h700
`define CNL_ID_LSS_RX    11'h7E5
`define CNL_ID_LSS_TX    11'h7E4

// network management commands
`define CNL_NMT_START    8'h01
`define CNL_NMT_STOP     8'h02
`define CNL_NMT_PREOP    8'h80
`define CNL_NMT_RST_APP  8'h81
`define CNL_NMT_RST_COM  8'h82

// layer-setting commands and reply codes
`define CNL_LSS_SWITCH   8'h04
`define CNL_LSS_CFG_ON   8'h01
`define CNL_LSS_SET_ID   8'h11
`define CNL_LSS_SET_RATE 8'h13
`define CNL_LSS_STORE    8'h17
`define CNL_LSS_INQ_VEN  8'h5A
`define CNL_LSS_INQ_PRD  8'h5B
`define CNL_LSS_INQ_REV  8'h5C
`define CNL_LSS_INQ_SER  8'h5D
`define CNL_LSS_OK       8'h00
`define CNL_LSS_ERR      8'h01

// frame format
`define CNL_MAX_DLC      4'h8
`define CNL_NODE_MAX     7'h7F
`define CNL_EMCY_ERRREG  8'h01

// reset values
`define CNL_RST_NODE     7'h7F
`define CNL_RST_RATE     8'h02

// transmit queue
`define CNL_TXW          79
`define CNL_TXD          32
`define CNL_TXAW         5

`endif

// *** design/cnl_fifo.v ***
// Purpose: transmit frame queue between the arbiter and the CAN controller
// Assumes: single clock, asynchronous active-low reset
// Notes:   read data is taken straight from the array, not registered
module cnl_fifo #(
	parameter W  = 79,
	parameter D  = 32,
	parameter AW = 5
) (
	input  wire          clk,
	input  wire          rst_b,
	input  wire          in_valid,
	output wire          in_ready,
	input  wire [W-1:0]  in_data,
	output wire          out_valid,
	input  wire          out_ready,
	output wire [W-1:0]  out_data
);
	reg  [W-1:0] mem [0:D-1];
	reg  [AW-1:0] wp_ff;
	reg  [AW-1:0] rp_ff;
	reg  [AW:0]   cnt_ff;
	wire          do_wr;
	wire          do_rd;

	assign in_ready  = (cnt_ff != D[AW:0]);
	assign out_valid = (cnt_ff != {(AW+1){1'b0}});
	assign out_data  = mem[rp_ff];
	assign do_wr     = in_valid & in_ready;
	assign do_rd     = out_valid & out_ready;

	always @(posedge clk) begin
		if (do_wr)
			mem[wp_ff] <= in_data;
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_ff  <= {AW{1'b0}};
			rp_ff  <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else begin
			if (do_wr)
				wp_ff <= wp_ff + 1'b1;
			if (do_rd)
				rp_ff <= rp_ff + 1'b1;
			if (do_wr & ~do_rd)
				cnt_ff <= cnt_ff + 1'b1;
			else if (do_rd & ~do_wr)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule // cnl_fifo

// *** design/cnl_rate.v ***
// Purpose: bit-rate table index to kbit/s decode
// Assumes: index 05 and anything above 08 are unsupported
// Notes:   purely combinational
module cnl_rate (
	input  wire [7:0] idx,
	output reg        ok,
	output reg  [9:0] kbps
);
	always @* begin
		ok = 1'b1;
		case (idx)
		8'h00: kbps = 10'h3E8;
		8'h01: kbps = 10'h320;
		8'h02: kbps = 10'h1F4;
		8'h03: kbps = 10'h0FA;
		8'h04: kbps = 10'h07D;
		8'h06: kbps = 10'h032;
		8'h07: kbps = 10'h014;
		8'h08: kbps = 10'h00A;
		default: begin
			ok   = 1'b0;
			kbps = 10'h000;
		end
		endcase
	end
endmodule // cnl_rate

// *** design/cnl_node.v ***
// Purpose: CANopen slave communication side with layer-setting services
// Assumes: CAN controller delivers whole received frames and takes whole
//          frames to send; all ports on CLK
// Notes:   object dictionary lives outside; requests pass through SDO_REQ
`include "cnl_defs.vh"

module cnl_node #(
	parameter [31:0] VENDOR_ID = 32'h0000_1234, // arbitrary value
	parameter [31:0] PRODUCT   = 32'h0000_0001, // arbitrary value
	parameter [31:0] REVISION  = 32'h0000_0001  // arbitrary value
) (
	input  wire        CLK,
	input  wire        RST_B,
	input  wire        RX_VALID,
	input  wire [10:0] RX_ID,
	input  wire        RX_RTR,
	input  wire [3:0]  RX_DLC,
	input  wire [63:0] RX_DATA,
	input  wire        TX_READY,
	output reg         TX_VALID,
	output reg  [10:0] TX_ID,
	output reg  [3:0]  TX_DLC,
	output reg  [63:0] TX_DATA,
	input  wire [6:0]  NV_NODE_ID,
	input  wire [7:0]  NV_RATE_IDX,
	input  wire [31:0] SERIAL_NUM,
	output reg         NV_WR,
	output reg  [6:0]  NV_WR_NODE_ID,
	output reg  [7:0]  NV_WR_RATE_IDX,
	input  wire        SYNC_MODE,
	input  wire        GUARD_DISABLE,
	input  wire        POS_EVT,
	input  wire [31:0] POSITION,
	input  wire [15:0] SPEED,
	input  wire        EMCY_REQ,
	input  wire [15:0] EMCY_CODE,
	output reg         SDO_REQ,
	output reg  [63:0] SDO_REQ_DATA,
	input  wire        SDO_RSP_VALID,
	input  wire [63:0] SDO_RSP_DATA,
	output reg  [6:0]  NMT_STATE,
	output reg  [6:0]  NODE_ID,
	output reg         LSS_CONFIG,
	output reg  [7:0]  RATE_IDX,
	output reg  [9:0]  RATE_KBPS
);
	function [7:0] byte_of;
		input [63:0] d;
		input [2:0]  i;
		byte_of = d[i*8 +: 8];
	endfunction
	function id_ok;
		input [7:0] b;
		id_ok = (b != 8'h00) && (b <= {1'b0, `CNL_NODE_MAX});
	endfunction
	// transmit sources, highest priority first
	localparam [2:0] SRC_NONE = 3'h0;
	localparam [2:0] SRC_BOOT = 3'h1;
	localparam [2:0] SRC_EMCY = 3'h2;
	localparam [2:0] SRC_LSS  = 3'h3;
	localparam [2:0] SRC_SDO  = 3'h4;
	localparam [2:0] SRC_GRD  = 3'h5;
	localparam [2:0] SRC_PDO  = 3'h6;
	reg         loaded_ff;
	reg         rate_loaded_ff;
	reg  [7:0]  cfg_rate_ff;
	reg         boot_pend_ff;
	reg         emcy_pend_ff;
	reg  [15:0] emcy_code_ff;
	reg         lss_pend_ff;
	reg  [63:0] lss_dat_ff;
	reg         sdo_pend_ff;
	reg  [63:0] sdo_dat_ff;
	reg         grd_pend_ff;
	reg         toggle_ff;
	reg         pdo_pend_ff;
	reg  [47:0] pdo_dat_ff;
	reg  [47:0] pos_ff;
	reg  [2:0]             src;
	reg  [`CNL_TXW-1:0]    q_word;
	wire                   q_ready;
	wire                   q_valid;
	wire [`CNL_TXW-1:0]    q_out;
	wire                   q_pop;
	wire                   cfg_ok;
	wire [9:0]             cfg_kbps;
	wire                   act_ok;
	wire [9:0]             act_kbps;
	////////////////////////////////////////////////////////////////////////
	// receive decode
	// valid frame with data length at most 8
	wire        rx_ok   = RX_VALID && (RX_DLC <= `CNL_MAX_DLC);
	wire [7:0]  b0      = byte_of(RX_DATA, 3'h0);
	wire [7:0]  b1      = byte_of(RX_DATA, 3'h1);
	wire [7:0]  b2      = byte_of(RX_DATA, 3'h2);
	wire [10:0] nid11   = {4'h0, NODE_ID};
	wire        live    = (NMT_STATE == `CNL_ST_PREOP) ||
	                      (NMT_STATE == `CNL_ST_OPER);
	wire        is_nmt  = rx_ok && !RX_RTR && (RX_ID == `CNL_ID_NMT);
	wire        is_lss  = rx_ok && !RX_RTR && (RX_ID == `CNL_ID_LSS_RX);
	wire        nmt_hit = is_nmt &&
	                      ((b1 == 8'h00) || (b1 == {1'b0, NODE_ID}));
	cnl_rate u_cfg_rate (
		.idx  (b2),
		.ok   (cfg_ok),
		.kbps (cfg_kbps)
	);
	cnl_rate u_act_rate (
		.idx  (RATE_IDX),
		.ok   (act_ok),
		.kbps (act_kbps)
	);
	////////////////////////////////////////////////////////////////////////
	// transmit arbiter
	always @* begin
		src    = SRC_NONE;
		q_word = {`CNL_TXW{1'b0}};
		if (boot_pend_ff) begin
			src    = SRC_BOOT;
			q_word = {`CNL_ID_GUARD_B + nid11, 4'h1, 64'h0};
		end else if (emcy_pend_ff) begin
			src    = SRC_EMCY;
			q_word = {`CNL_ID_EMCY_B + nid11, 4'h8, 40'h0,
			          `CNL_EMCY_ERRREG, emcy_code_ff};
		end else if (lss_pend_ff) begin
			src    = SRC_LSS;
			q_word = {`CNL_ID_LSS_TX, 4'h8, lss_dat_ff};
		end else if (sdo_pend_ff) begin
			src    = SRC_SDO;
			q_word = {`CNL_ID_SDOTX_B + nid11, 4'h8, sdo_dat_ff};
		end else if (grd_pend_ff) begin
			src    = SRC_GRD;
			q_word = {`CNL_ID_GUARD_B + nid11, 4'h1, 56'h0,
			          toggle_ff, NMT_STATE};
		end else if (pdo_pend_ff) begin
			src    = SRC_PDO;
			q_word = {`CNL_ID_PDO1_B + nid11, 4'h6, 16'h0, pdo_dat_ff};
		end
	end
	// a full queue stalls the arbiter; pending flags just wait
	wire q_push = (src != SRC_NONE) && q_ready;
	cnl_fifo #(
		.W  (`CNL_TXW),
		.D  (`CNL_TXD),
		.AW (`CNL_TXAW)
	) u_txq (
		.clk       (CLK),
		.rst_b     (RST_B),
		.in_valid  (src != SRC_NONE),
		.in_ready  (q_ready),
		.in_data   (q_word),
		.out_valid (q_valid),
		.out_ready (q_pop),
		.out_data  (q_out)
	);
	assign q_pop = q_valid && (!TX_VALID || TX_READY);
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			TX_VALID <= 1'b0;
			TX_ID    <= 11'h000;
			TX_DLC   <= 4'h0;
			TX_DATA  <= 64'h0;
		end else if (q_pop) begin
			TX_VALID <= 1'b1;
			TX_ID    <= q_out[78:68];
			TX_DLC   <= q_out[67:64];
			TX_DATA  <= q_out[63:0];
		end else if (TX_READY) begin
			TX_VALID <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// network state, storage load, node identifier
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			loaded_ff      <= 1'b0;
			rate_loaded_ff <= 1'b0;
			NODE_ID        <= `CNL_RST_NODE;
			RATE_IDX       <= `CNL_RST_RATE;
			cfg_rate_ff    <= `CNL_RST_RATE;
			NMT_STATE      <= `CNL_ST_INIT;
			boot_pend_ff   <= 1'b0;
		end else begin
			if (!loaded_ff) begin
				loaded_ff    <= 1'b1;
				boot_pend_ff <= 1'b1;
				if (id_ok({1'b0, NV_NODE_ID}))
					NODE_ID <= NV_NODE_ID;
				if (!rate_loaded_ff) begin
					rate_loaded_ff <= 1'b1;
					RATE_IDX       <= NV_RATE_IDX;
					cfg_rate_ff    <= NV_RATE_IDX;
				end
			end else if (src == SRC_BOOT && q_push) begin
				boot_pend_ff <= 1'b0;
				NMT_STATE    <= `CNL_ST_PREOP;
			end else if (nmt_hit && NMT_STATE != `CNL_ST_INIT) begin
				case (b0)
				`CNL_NMT_START: NMT_STATE <= `CNL_ST_OPER;
				`CNL_NMT_STOP:  NMT_STATE <= `CNL_ST_STOPPED;
				`CNL_NMT_PREOP: NMT_STATE <= `CNL_ST_PREOP;
				`CNL_NMT_RST_APP, `CNL_NMT_RST_COM: begin
					NMT_STATE <= `CNL_ST_INIT;
					loaded_ff <= 1'b0;
				end
				default: NMT_STATE <= NMT_STATE;
				endcase
			end
			if (is_lss && LSS_CONFIG) begin
				// new identifier in force at once
				if (b0 == `CNL_LSS_SET_ID && id_ok(b1))
					NODE_ID <= b1[6:0];
				if (b0 == `CNL_LSS_SET_RATE && b1 == 8'h00 && cfg_ok)
					cfg_rate_ff <= b2;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// layer-setting replies and storage writes
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			LSS_CONFIG     <= 1'b0;
			lss_pend_ff    <= 1'b0;
			lss_dat_ff     <= 64'h0;
			NV_WR          <= 1'b0;
			NV_WR_NODE_ID  <= 7'h00;
			NV_WR_RATE_IDX <= 8'h00;
		end else begin
			NV_WR <= 1'b0;
			if (src == SRC_LSS && q_push)
				lss_pend_ff <= 1'b0;
			if (is_lss) begin
				if (b0 == `CNL_LSS_SWITCH) begin
					LSS_CONFIG <= (b1 == `CNL_LSS_CFG_ON);
				end else if (LSS_CONFIG) begin
					lss_pend_ff <= 1'b1;
					case (b0)
					`CNL_LSS_SET_ID:
						lss_dat_ff <= {48'h0,
							id_ok(b1) ? `CNL_LSS_OK : `CNL_LSS_ERR,
							b0};
					`CNL_LSS_SET_RATE:
						lss_dat_ff <= {48'h0,
							(cfg_ok && b1 == 8'h00) ?
							`CNL_LSS_OK : `CNL_LSS_ERR, b0};
					`CNL_LSS_STORE: begin
						NV_WR          <= 1'b1;
						NV_WR_NODE_ID  <= NODE_ID;
						NV_WR_RATE_IDX <= cfg_rate_ff;
						lss_dat_ff     <= {56'h0, b0};
					end
					`CNL_LSS_INQ_VEN: lss_dat_ff <= {24'h0, VENDOR_ID, b0};
					`CNL_LSS_INQ_PRD: lss_dat_ff <= {24'h0, PRODUCT, b0};
					`CNL_LSS_INQ_REV: lss_dat_ff <= {24'h0, REVISION, b0};
					`CNL_LSS_INQ_SER: lss_dat_ff <= {24'h0, SERIAL_NUM, b0};
					default: lss_pend_ff <= lss_pend_ff;
					endcase
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// service data, guard, emergency, process data
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			SDO_REQ      <= 1'b0;
			SDO_REQ_DATA <= 64'h0;
			sdo_pend_ff  <= 1'b0;
			sdo_dat_ff   <= 64'h0;
			grd_pend_ff  <= 1'b0;
			toggle_ff    <= 1'b0;
			emcy_pend_ff <= 1'b0;
			emcy_code_ff <= 16'h0;
			pdo_pend_ff  <= 1'b0;
			pdo_dat_ff   <= 48'h0;
			pos_ff       <= 48'h0;
			RATE_KBPS    <= 10'h000;
		end else begin
			RATE_KBPS <= act_ok ? act_kbps : 10'h000;
			SDO_REQ   <= 1'b0;
			// clears first so a same-cycle event wins
			if (src == SRC_SDO && q_push)
				sdo_pend_ff <= 1'b0;
			if (src == SRC_GRD && q_push) begin
				grd_pend_ff <= 1'b0;
				toggle_ff   <= ~toggle_ff;
			end
			if (src == SRC_EMCY && q_push)
				emcy_pend_ff <= 1'b0;
			if (src == SRC_PDO && q_push)
				pdo_pend_ff <= 1'b0;
			if (!live)
				pdo_pend_ff <= 1'b0;
			if (rx_ok && !RX_RTR && live &&
			    RX_ID == `CNL_ID_SDORX_B + nid11) begin
				SDO_REQ      <= 1'b1;
				SDO_REQ_DATA <= RX_DATA;
			end
			if (SDO_RSP_VALID && live) begin
				sdo_pend_ff <= 1'b1;
				sdo_dat_ff  <= SDO_RSP_DATA;
			end
			if (rx_ok && RX_RTR && !GUARD_DISABLE &&
			    NMT_STATE != `CNL_ST_INIT &&
			    RX_ID == `CNL_ID_GUARD_B + nid11)
				grd_pend_ff <= 1'b1;
			if (EMCY_REQ && live) begin
				emcy_pend_ff <= 1'b1;
				emcy_code_ff <= EMCY_CODE;
			end
			if (POS_EVT)
				pos_ff <= {SPEED, POSITION};
			if (NMT_STATE == `CNL_ST_OPER) begin
				if (SYNC_MODE && rx_ok && !RX_RTR &&
				    RX_ID == `CNL_ID_SYNC) begin
					pdo_pend_ff <= 1'b1;
					pdo_dat_ff  <= pos_ff;
				end else if (!SYNC_MODE && POS_EVT) begin
					pdo_pend_ff <= 1'b1;
					pdo_dat_ff  <= {SPEED, POSITION};
				end
			end
		end
	end
endmodule // cnl_node

// *** verification/cnl_master.sv ***
// Purpose: CAN master model: sinks device frames, sources bus frames
// Assumes: whole frames per beat, same clock as the node
// Notes:   released lines show the inverse of the last frame
module cnl_master (
	input  wire         CLK,
	input  wire         TX_VALID,
	input  wire  [10:0] TX_ID,
	input  wire  [3:0]  TX_DLC,
	input  wire  [63:0] TX_DATA,
	output logic        TX_READY,
	output logic        RX_VALID,
	output logic [10:0] RX_ID,
	output logic        RX_RTR,
	output logic [3:0]  RX_DLC,
	output logic [63:0] RX_DATA
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [78:0] q[$];
	bit          slow = 0;
	bit          stall = 0;
	initial begin
		RX_VALID = 0;
		{RX_ID, RX_RTR, RX_DLC, RX_DATA} = '0;
	end
	// same rate assumed, no bit timing modelled
	always @(negedge CLK) begin
		TX_READY <= stall ? 1'b0 : slow ? 1'($urandom_range(1)) : 1'b1;
	end
	always @(posedge CLK) begin
		if (TX_VALID && TX_READY)
			q.push_back({TX_ID, TX_DLC, TX_DATA});
	end
	// base frames, single node on the bus
	task send(input [10:0] id, input rtr, input [3:0] dlc, input [63:0] d);
		@(negedge CLK);
		{RX_VALID, RX_ID, RX_RTR, RX_DLC, RX_DATA} = {1'b1, id, rtr, dlc, d};
		@(negedge CLK);
		{RX_VALID, RX_ID, RX_RTR, RX_DLC, RX_DATA} = {1'b0, ~id, ~rtr, ~dlc, ~d};
	endtask
endmodule // cnl_master

// *** verification/cnl_node_checker.sv ***
// Purpose: port-level checks on cnl_node
// Assumes: one clock, RST_B asynchronous active low
// Notes:   startup counter saturates at 3
`include "cnl_defs.vh"
module cnl_checker (
	input wire        CLK,
	input wire        RST_B,
	input wire        RX_VALID,
	input wire [10:0] RX_ID,
	input wire [3:0]  RX_DLC,
	input wire [63:0] RX_DATA,
	input wire        TX_READY,
	input wire        TX_VALID,
	input wire [10:0] TX_ID,
	input wire [3:0]  TX_DLC,
	input wire [63:0] TX_DATA,
	input wire        NV_WR,
	input wire        SDO_REQ,
	input wire [6:0]  NMT_STATE,
	input wire [6:0]  NODE_ID,
	input wire        LSS_CONFIG,
	input wire [7:0]  RATE_IDX
);
	reg [1:0] cnt_ff;
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B)
			cnt_ff <= 2'h0;
		else if (cnt_ff != 2'h3)
			cnt_ff <= cnt_ff + 2'h1;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	wire lss = RX_VALID && RX_ID == `CNL_ID_LSS_RX && RX_DLC <= 4'h8;
	sequence s_preop;
		NMT_STATE == `CNL_ST_PREOP;
	endsequence
	sequence s_boot;
		TX_VALID && TX_ID == (11'h700 | NODE_ID) && TX_DLC == 4'h1
			&& TX_DATA[7:0] == 8'h00;
	endsequence
	property p_boot;
		cnt_ff == 2'h2 |-> s_preop ##1 s_boot;
	endproperty
	property p_hold;
		TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_ID)
			&& $stable(TX_DATA) && $stable(TX_DLC);
	endproperty
	property p_dlc;
		TX_VALID |-> TX_DLC <= `CNL_MAX_DLC;
	endproperty
	property p_pdo;
		TX_VALID && TX_ID == 11'h180 + NODE_ID |-> NMT_STATE == `CNL_ST_OPER;
	endproperty
	property p_sdo;
		SDO_REQ |-> NMT_STATE == `CNL_ST_OPER || NMT_STATE == `CNL_ST_PREOP;
	endproperty
	property p_node;
		NODE_ID != 7'h00;
	endproperty
	property p_nvwr;
		NV_WR |=> !NV_WR;
	endproperty
	property p_rate;
		cnt_ff == 2'h3 |-> $stable(RATE_IDX);
	endproperty
	property p_cfg;
		lss && RX_DATA[15:0] == 16'h0104 |=> LSS_CONFIG;
	endproperty
	property p_setid;
		lss && LSS_CONFIG && RX_DATA[7:0] == 8'h11 && RX_DATA[15:8] != 8'h00
			&& !RX_DATA[15] |=> NODE_ID == $past(RX_DATA[14:8]);
	endproperty
	a_boot: assert property (p_boot) else $error("boot frame wrong");
	a_hold: assert property (p_hold) else $error("tx changed early");
	a_dlc: assert property (p_dlc) else $error("tx length over 8");
	a_pdo: assert property (p_pdo) else $error("pdo not oper");
	a_sdo: assert property (p_sdo) else $error("sdo in bad state");
	a_node: assert property (p_node) else $error("node id zero");
	a_nvwr: assert property (p_nvwr) else $error("store not pulse");
	a_rate: assert property (p_rate) else $error("rate moved");
	a_cfg: assert property (p_cfg) else $error("no config mode");
	a_setid: assert property (p_setid) else $error("id not applied");
endmodule // cnl_checker

bind cnl_node cnl_checker u_cnl_checker (.CLK, .RST_B, .RX_VALID, .RX_ID,
	.RX_DLC, .RX_DATA, .TX_READY, .TX_VALID, .TX_ID, .TX_DLC, .TX_DATA,
	.NV_WR, .SDO_REQ, .NMT_STATE, .NODE_ID, .LSS_CONFIG, .RATE_IDX);

// *** verification/cnl_node_tb.sv ***
// Purpose: self-checking bench for cnl_node and its queue
// Assumes: cnl_master stands for the bus master
// Notes:   expectations are written out in the sequence from the bench's own stimulus values
`include "cnl_defs.vh"
module cnl_node_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [31:0] VEN = 32'h0000_ABCD; // arbitrary value
	logic        CLK, RST_B, RX_VALID, RX_RTR, TX_READY, TX_VALID, NV_WR;
	logic        SYNC_MODE, GUARD_DISABLE, POS_EVT, EMCY_REQ, SDO_REQ;
	logic        SDO_RSP_VALID, LSS_CONFIG;
	logic [10:0] RX_ID, TX_ID;
	logic [3:0]  RX_DLC, TX_DLC;
	logic [63:0] RX_DATA, TX_DATA, SDO_REQ_DATA, SDO_RSP_DATA, d;
	logic [6:0]  NV_NODE_ID, NV_WR_NODE_ID, NMT_STATE, NODE_ID, m_node;
	logic [7:0]  NV_RATE_IDX, NV_WR_RATE_IDX, RATE_IDX;
	logic [31:0] SERIAL_NUM, POSITION;
	logic [15:0] SPEED, EMCY_CODE;
	logic [9:0]  RATE_KBPS;
	int          fails = 0, cmp_count = 0, cyc = 0, n, k;
	cnl_node #(.VENDOR_ID(VEN)) u_cnl_node (.CLK, .RST_B, .RX_VALID, .RX_ID,
		.RX_RTR, .RX_DLC, .RX_DATA, .TX_READY, .TX_VALID, .TX_ID, .TX_DLC,
		.TX_DATA, .NV_NODE_ID, .NV_RATE_IDX, .SERIAL_NUM, .NV_WR,
		.NV_WR_NODE_ID, .NV_WR_RATE_IDX, .SYNC_MODE, .GUARD_DISABLE, .POS_EVT,
		.POSITION, .SPEED, .EMCY_REQ, .EMCY_CODE, .SDO_REQ, .SDO_REQ_DATA,
		.SDO_RSP_VALID, .SDO_RSP_DATA, .NMT_STATE, .NODE_ID, .LSS_CONFIG,
		.RATE_IDX, .RATE_KBPS);
	cnl_master u_cnl_master (.CLK, .TX_VALID, .TX_ID, .TX_DLC, .TX_DATA,
		.TX_READY, .RX_VALID, .RX_ID, .RX_RTR, .RX_DLC, .RX_DATA);
	////////////////////////////////////////////////////////////////////////
	task conclude;
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk_val(input string nm, input logic [63:0] e, g);
		cmp_count++;
		if (e !== g) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task chk_frm(input logic [78:0] e, g);
		cmp_count++;
		if (e !== g) begin
			fails++;
			$display("[ERR] frame exp %h got %h", e, g);
		end
	endtask
	task expf(input [10:0] id, input [3:0] dlc, input [63:0] dd);
		logic [78:0] f;
		f = 'x;
		for (k = 0; k < 300 && u_cnl_master.q.size() == 0; k++)
			@(negedge CLK);
		if (u_cnl_master.q.size() > 0)
			f = u_cnl_master.q.pop_front();
		chk_frm({id, dlc, dd}, f);
	endtask
	task quiet;
		repeat (12) @(negedge CLK);
		chk_val("queue", 0, u_cnl_master.q.size());
	endtask
	task lss(input [63:0] dd);
		u_cnl_master.send(`CNL_ID_LSS_RX, 0, 4'h8, dd);
	endtask
	task nmt(input [7:0] c, input [6:0] st);
		u_cnl_master.send(`CNL_ID_NMT, 0, 4'h2, {56'h0, c});
		repeat (3) @(negedge CLK);
		chk_val("state", st, NMT_STATE);
	endtask
	task guard;
		u_cnl_master.send(11'h700 + m_node, 1, 4'h0, 64'h0);
	endtask
	task evt(input e);
		@(negedge CLK);
		{POS_EVT, EMCY_REQ} = {1'b1, e};
		@(negedge CLK);
		{POS_EVT, EMCY_REQ} = 2'h0;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		CLK = 0;
		forever #25 CLK = ~CLK;
	end
	// hang guard, run needs a few hundred cycles
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			conclude;
		end
	end
	initial begin
		k = $urandom(32'h266cde66);
		{RST_B, SYNC_MODE, GUARD_DISABLE, POS_EVT, EMCY_REQ} = 5'h0;
		{SDO_RSP_VALID, SDO_RSP_DATA} = '0;
		{NV_NODE_ID, NV_RATE_IDX, m_node} = {7'h0A, 8'h04, 7'h0A};
		{SERIAL_NUM, POSITION} = {$urandom, $urandom};
		{SPEED, EMCY_CODE} = {16'($urandom), 16'($urandom)};
		repeat (20) @(negedge CLK);
		RST_B = 1;
		expf(11'h70A, 4'h1, 64'h0);
		chk_val("kbps", 10'h07D, RATE_KBPS);
		guard;
		expf(11'h70A, 4'h1, 64'h7F);
		guard;
		expf(11'h70A, 4'h1, 64'hFF);
		d = {$urandom, $urandom};
		u_cnl_master.send(11'h60A, 0, 4'h8, d);
		for (k = 0; k < 10 && SDO_REQ !== 1'b1; k++)
			@(negedge CLK);
		chk_val("sdo_pulse", 1, SDO_REQ);
		chk_val("sdo_req", d, SDO_REQ_DATA);
		{SDO_RSP_VALID, SDO_RSP_DATA} = {1'b1, ~d};
		@(negedge CLK);
		SDO_RSP_VALID = 0;
		expf(11'h58A, 4'h8, ~d);
		evt(0);
		quiet;
		nmt(`CNL_NMT_START, `CNL_ST_OPER);
		u_cnl_master.slow = 1;
		evt(0);
		expf(11'h18A, 4'h6, {16'h0, SPEED, POSITION});
		evt(1);
		expf(11'h08A, 4'h8, {40'h0, 8'h01, EMCY_CODE});
		expf(11'h18A, 4'h6, {16'h0, SPEED, POSITION});
		SYNC_MODE = 1;
		evt(0);
		quiet;
		d = {16'h0, SPEED, POSITION};
		POSITION = $urandom;
		u_cnl_master.send(`CNL_ID_SYNC, 0, 4'h0, 64'h0);
		expf(11'h18A, 4'h6, d);
		SYNC_MODE = 0;
		u_cnl_master.slow = 0;
		nmt(`CNL_NMT_STOP, `CNL_ST_STOPPED);
		evt(1);
		quiet;
		guard;
		expf(11'h70A, 4'h1, 64'h04);
		nmt(`CNL_NMT_PREOP, `CNL_ST_PREOP);
		lss(64'h0104);
		repeat (2) @(negedge CLK);
		chk_val("lss_cfg", 1, LSS_CONFIG);
		lss(64'h0011);
		expf(`CNL_ID_LSS_TX, 4'h8, 64'h0111);
		lss(64'h7D11);
		repeat (2) @(negedge CLK);
		chk_val("node", 7'h7D, NODE_ID);
		expf(`CNL_ID_LSS_TX, 4'h8, 64'h0011);
		for (n = 9; n >= 0; n--) begin
			lss({40'h0, 8'(n), 16'h0013});
			d = (n == 5 || n > 8) ? 64'h0113 : 64'h0013;
			expf(`CNL_ID_LSS_TX, 4'h8, d);
		end
		chk_val("rate", 8'h04, RATE_IDX);
		lss(64'h5A);
		expf(`CNL_ID_LSS_TX, 4'h8, {24'h0, VEN, 8'h5A});
		lss(64'h5D);
		expf(`CNL_ID_LSS_TX, 4'h8, {24'h0, SERIAL_NUM, 8'h5D});
		u_cnl_master.send(`CNL_ID_LSS_RX, 0, 4'h1, 64'h17);
		for (k = 0; k < 10 && NV_WR !== 1'b1; k++)
			@(negedge CLK);
		chk_val("nv_pulse", 1, NV_WR);
		chk_val("nv_wr", {7'h7D, 8'h00}, {NV_WR_NODE_ID, NV_WR_RATE_IDX});
		expf(`CNL_ID_LSS_TX, 4'h8, 64'h0017);
		RST_B = 0;
		repeat (2) @(negedge CLK);
		{NV_NODE_ID, NV_RATE_IDX, m_node, RST_B} = {7'h7D, 8'h00, 7'h7D, 1'b1};
		expf(11'h77D, 4'h1, 64'h0);
		chk_val("kbps", 10'h3E8, RATE_KBPS);
		GUARD_DISABLE = 1;
		guard;
		quiet;
		// controller stalled: 32 queued, 1 offered, 1 left pending
		GUARD_DISABLE = 0;
		u_cnl_master.stall = 1;
		for (n = 0; n < 40; n++)
			guard;
		repeat (2) @(negedge CLK);
		chk_val("stalled", 0, u_cnl_master.q.size());
		u_cnl_master.stall = 0;
		for (n = 0; n < 34; n++)
			expf(11'h77D, 4'h1, {56'h0, n[0], 7'h7F});
		quiet;
		conclude;
	end
endmodule // cnl_node_tb
